// File: pio_pkg.sv
package pio_pkg;

	// Pin population: ports 0 to 5 full, port 6 low nibble, port 7 bit 0.
	localparam int          PIO_NUM_PINS   = 53;
	localparam int          PIO_PIN_W      = 64;
	localparam int          PIO_XBAR_W     = 23;
	localparam logic [63:0] PIO_POP_MASK   = 64'h010F_FFFF_FFFF_FFFF;
	localparam logic [63:0] PIO_XBAR_MASK  = 64'h0000_0000_007F_FFFF;
	localparam logic [63:0] PIO_DIG_ONLY   = 64'h0100_0000_0000_0000;

	// Pins with fixed functions, as flat indices port*8+bit.
	localparam int          PIO_PIN_ANALOG_GROUND_REF_PIN    = 1;
	localparam int          PIO_PIN_OSC_IN  = 2;
	localparam int          PIO_PIN_OSC_OUT = 3;
	localparam int          PIO_PIN_DEBUG   = 56;

	// Register byte offsets; each pin kind has one word per port at +4*port, GCTRL a single word.
	localparam logic [11:0] PIO_OFF_LATCH  = 12'h000;
	localparam logic [11:0] PIO_OFF_INPUT  = 12'h020;
	localparam logic [11:0] PIO_OFF_MDIN   = 12'h040;
	localparam logic [11:0] PIO_OFF_MDOUT  = 12'h060;
	localparam logic [11:0] PIO_OFF_DRV    = 12'h080;
	localparam logic [11:0] PIO_OFF_SKIP   = 12'h0A0;
	localparam logic [11:0] PIO_OFF_GCTRL  = 12'h0C0;

	// Global control fields.
	localparam int          PIO_GCTRL_XBAR = 0;
	localparam int          PIO_GCTRL_PUD  = 1;

	// Reset values.
	localparam logic [63:0] PIO_RST_LATCH  = PIO_POP_MASK;
	localparam logic [63:0] PIO_RST_MDIN   = PIO_POP_MASK;
	localparam logic [63:0] PIO_RST_MDOUT  = 64'h0000_0000_0000_0000;
	localparam logic [63:0] PIO_RST_DRV    = 64'h0000_0000_0000_0000;
	localparam logic [63:0] PIO_RST_SKIP   = 64'h0000_0000_0000_0000;
	localparam logic        PIO_RST_XBAR   = 1'h0;
	localparam logic        PIO_RST_PUD    = 1'h0;

	// Bus encodings.
	localparam logic [1:0]  PIO_HTRANS_NSEQ = 2'h2;
	localparam logic        PIO_HRESP_OKAY  = 1'h0;

endpackage : pio_pkg

// File: pio_cell.sv
`timescale 1ns/1ps
`default_nettype none
// One pad cell: turns the pin configuration into registered pad controls.
module pio_cell #(
	parameter bit PRESENT = 1'b1
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic digital,
	input  wire logic push_pull,
	input  wire logic out_val,
	input  wire logic out_ok,
	input  wire logic pud,
	input  wire logic drv_high,
	output logic      pad_oe,
	output logic      pad_out,
	output logic      pullup_en,
	output logic      input_en,
	output logic      drive_high
);
	logic drv_hi_c;
	logic drv_lo_c;
	logic oe_next;
	logic out_next;
	logic pu_next;
	logic in_next;
	logic dh_next;

	// Driver, pull-up and receiver decisions for this cell.
	always_comb begin
		drv_hi_c = digital && out_ok && push_pull && out_val;
		drv_lo_c = digital && out_ok && !out_val;
		oe_next  = PRESENT && (drv_hi_c || drv_lo_c);
		out_next = PRESENT && drv_hi_c;
		pu_next  = PRESENT && digital && !oe_next && !pud;
		in_next  = PRESENT && digital;
		dh_next  = PRESENT && drv_high;
	end

	// Outputs come from flops; reset leaves a floating pulled-up input.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad_oe     <= 1'b0;
			pad_out    <= 1'b0;
			pullup_en  <= PRESENT;
			input_en   <= PRESENT;
			drive_high <= 1'b0;
		end else begin
			pad_oe     <= oe_next;
			pad_out    <= out_next;
			pullup_en  <= pu_next;
			input_en   <= in_next;
			drive_high <= dh_next;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_drive_on;
		PRESENT && digital && out_ok;
	endsequence

	a_analog_no_pull: assert property (!digital |=> !pullup_en && !input_en)
		else $error("Analog cell kept its pull-up or receiver.");
	a_push_pull_drive: assert property (s_drive_on and push_pull |=>
		pad_oe && pad_out == $past(out_val))
		else $error("Push-pull cell did not follow its output value.");
	a_open_drain_drive: assert property (s_drive_on and !push_pull |=>
		!pad_out && pad_oe == !$past(out_val))
		else $error("Open-drain cell drove high or missed a low.");
	a_pullup_gated: assert property (pad_oe || $past(pud) |-> !pullup_en)
		else $error("Pull-up active while driven or globally disabled.");

endmodule : pio_cell
`default_nettype wire

// File: pio_port_cfg.sv
`timescale 1ns/1ps
`default_nettype none
// Port I/O configuration block with an AHB-Lite register slave.
module pio_port_cfg
	import pio_pkg::*;
(
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	input  wire logic [pio_pkg::PIO_PIN_W-1:0]  pad_in,
	output logic      [pio_pkg::PIO_PIN_W-1:0]  pad_out,
	output logic      [pio_pkg::PIO_PIN_W-1:0]  pad_oe,
	output logic      [pio_pkg::PIO_PIN_W-1:0]  pad_pullup_en,
	output logic      [pio_pkg::PIO_PIN_W-1:0]  pad_input_en,
	output logic      [pio_pkg::PIO_PIN_W-1:0]  pad_drive_high,
	input  wire logic [pio_pkg::PIO_XBAR_W-1:0] xbar_assign,
	input  wire logic [pio_pkg::PIO_XBAR_W-1:0] xbar_data,
	output logic      [pio_pkg::PIO_XBAR_W-1:0] xbar_avail,
	input  wire logic                        debug_wire_active,
	input  wire logic                        debug_wire_drive_en,
	input  wire logic                        debug_wire_drive_val,
	output logic                             debug_wire_data,
	output logic                             ext_osc_input_pin_ready,
	output logic                             ext_osc_output_pin_ready,
	output logic                             analog_ground_ref_pin_ready
);
	import pio_pkg::*;

	// Configuration state, one bit per flat pin index, plus the two global control bits.
	logic [63:0] latch_reg;
	logic [63:0] latch_next;
	logic [63:0] pin_analog_digital_select_reg;
	logic [63:0] pin_analog_digital_select_next;
	logic [63:0] pin_output_mode_select_reg;
	logic [63:0] pin_output_mode_select_next;
	logic [63:0] pin_drive_strength_select_reg;
	logic [63:0] pin_drive_strength_select_next;
	logic [63:0] crossbar_skip_bit_reg;
	logic [63:0] crossbar_skip_bit_next;
	logic        crossbar_enable_bit_reg;
	logic        crossbar_enable_bit_next;
	logic        weak_pullup_global_disable_reg;
	logic        weak_pullup_global_disable_next;

	// Bus pipeline state.
	logic        wr_pend_reg;
	logic        wr_pend_next;
	logic [11:0] wr_addr_reg;
	logic [11:0] wr_addr_next;
	logic [31:0] hrdata_next;
	logic [PIO_XBAR_W-1:0] xbar_avail_next;
	logic        osc_in_next;
	logic        osc_out_next;
	logic        analog_ground_ref_pin_next;
	logic        dbg_next;

	// Combinational helpers.
	logic        take_c;
	logic        rd_take_c;
	logic [11:0] rd_base_c;
	logic [2:0]  rd_port_c;
	logic [7:0]  rd_byte_c;
	logic        rd_hit_c;
	logic [7:0]  rd_sel_c;
	logic [7:0]  rd_pad_c;
	logic [11:0] wr_base_c;
	logic [5:0]  wr_lsb_c;
	logic [63:0] pin_read_c;
	logic [63:0] analog_ready_c;
	logic [63:0] xbar_w_assign;
	logic [63:0] xbar_w_data;
	logic [63:0] pin_val_c;
	logic [63:0] pin_ok_c;
	logic [63:0] pin_pp_c;

	// Address phase capture; only whole-word single transfers are used.
	always_comb begin
		take_c       = hsel && hready && (htrans == PIO_HTRANS_NSEQ);
		rd_take_c    = take_c && !hwrite;
		wr_pend_next = take_c && hwrite;
		wr_addr_next = take_c ? haddr[11:0] : wr_addr_reg;
		wr_base_c    = {wr_addr_reg[11:5], 5'h00};
		wr_lsb_c     = {wr_addr_reg[4:2], 3'h0};
	end

	// Register writes land in the data phase; unused pins stay zero.
	always_comb begin
		latch_next                      = latch_reg;
		pin_analog_digital_select_next  = pin_analog_digital_select_reg;
		pin_output_mode_select_next     = pin_output_mode_select_reg;
		pin_drive_strength_select_next  = pin_drive_strength_select_reg;
		crossbar_skip_bit_next          = crossbar_skip_bit_reg;
		crossbar_enable_bit_next        = crossbar_enable_bit_reg;
		weak_pullup_global_disable_next = weak_pullup_global_disable_reg;
		if (wr_pend_reg) begin
			case (wr_base_c)
				PIO_OFF_LATCH: begin
					latch_next[wr_lsb_c +: 8] = hwdata[7:0];
				end
				PIO_OFF_MDIN: begin
					pin_analog_digital_select_next[wr_lsb_c +: 8] = hwdata[7:0];
				end
				PIO_OFF_MDOUT: begin
					pin_output_mode_select_next[wr_lsb_c +: 8] = hwdata[7:0];
				end
				PIO_OFF_DRV: begin
					pin_drive_strength_select_next[wr_lsb_c +: 8] = hwdata[7:0];
				end
				PIO_OFF_SKIP: begin
					crossbar_skip_bit_next[wr_lsb_c +: 8] = hwdata[7:0];
				end
				PIO_OFF_GCTRL: begin
					if (wr_addr_reg[4:2] == 3'h0) begin
						crossbar_enable_bit_next = hwdata[PIO_GCTRL_XBAR];
						weak_pullup_global_disable_next = hwdata[PIO_GCTRL_PUD];
					end
				end
				default: begin
				end
			endcase
		end
		latch_next                     = latch_next & PIO_POP_MASK;
		// P7.0 cannot be made analog, so its select bit stays at 1.
		pin_analog_digital_select_next = (pin_analog_digital_select_next &
			PIO_POP_MASK) | PIO_DIG_ONLY;
		pin_output_mode_select_next    = pin_output_mode_select_next &
			PIO_POP_MASK;
		pin_drive_strength_select_next = pin_drive_strength_select_next &
			PIO_POP_MASK;
		crossbar_skip_bit_next         = crossbar_skip_bit_next & PIO_POP_MASK;
	end

	// Read mux works on next values so a read right after a write sees it.
	always_comb begin
		rd_base_c  = {haddr[11:5], 5'h00};
		rd_port_c  = haddr[4:2];
		rd_sel_c   = pin_analog_digital_select_next[{rd_port_c, 3'h0} +: 8];
		rd_pad_c   = pad_in[{rd_port_c, 3'h0} +: 8];  // Kept for the checks.
		pin_read_c = pad_in & pin_analog_digital_select_next
			& PIO_POP_MASK;
		rd_hit_c   = 1'b1;
		rd_byte_c  = 8'h00;
		case (rd_base_c)
			PIO_OFF_LATCH: rd_byte_c = latch_next[{rd_port_c, 3'h0} +: 8];
			PIO_OFF_INPUT: rd_byte_c = pin_read_c[{rd_port_c, 3'h0} +: 8];
			PIO_OFF_MDIN: rd_byte_c =
				pin_analog_digital_select_next[{rd_port_c, 3'h0} +: 8];
			PIO_OFF_MDOUT: rd_byte_c =
				pin_output_mode_select_next[{rd_port_c, 3'h0} +: 8];
			PIO_OFF_DRV: rd_byte_c =
				pin_drive_strength_select_next[{rd_port_c, 3'h0} +: 8];
			PIO_OFF_SKIP: rd_byte_c =
				crossbar_skip_bit_next[{rd_port_c, 3'h0} +: 8];
			PIO_OFF_GCTRL: rd_byte_c = (rd_port_c == 3'h0) ?
				{6'h00, weak_pullup_global_disable_next,
				crossbar_enable_bit_next} : 8'h00;
			default: rd_hit_c = 1'b0;
		endcase
		hrdata_next = (rd_take_c && rd_hit_c) ? {24'h00_0000, rd_byte_c}
			: 32'h0000_0000;
	end

	// Per-pin drive source: crossbar for assigned unskipped low pins, else the latch.
	always_comb begin
		xbar_w_assign = {41'h000_0000_0000, xbar_assign};
		xbar_w_data   = {41'h000_0000_0000, xbar_data};
		for (int i = 0; i < PIO_PIN_W; i++) begin
			if (PIO_XBAR_MASK[i] && !crossbar_skip_bit_reg[i]
				&& xbar_w_assign[i]) begin
				pin_val_c[i] = xbar_w_data[i];
			end else begin
				pin_val_c[i] = latch_reg[i];
			end
			pin_ok_c[i] = crossbar_enable_bit_reg;
			pin_pp_c[i] = pin_output_mode_select_reg[i];
		end
		// The debug data signal takes over P7.0 while it is active.
		if (debug_wire_active) begin
			pin_val_c[PIO_PIN_DEBUG] = debug_wire_drive_val;
			pin_ok_c[PIO_PIN_DEBUG]  = debug_wire_drive_en;
			pin_pp_c[PIO_PIN_DEBUG]  = 1'b1;
		end
	end

	// Analog fixed-function readiness and crossbar pin availability.
	always_comb begin
		analog_ready_c  = ~pin_analog_digital_select_next &
			~pin_output_mode_select_next & latch_next &
			crossbar_skip_bit_next & PIO_POP_MASK;
		xbar_avail_next = PIO_XBAR_W'(~crossbar_skip_bit_next &
			PIO_XBAR_MASK);
		osc_in_next     = analog_ready_c[PIO_PIN_OSC_IN];
		osc_out_next    = analog_ready_c[PIO_PIN_OSC_OUT];
		analog_ground_ref_pin_next       = analog_ready_c[PIO_PIN_ANALOG_GROUND_REF_PIN];
		dbg_next        = pad_in[PIO_PIN_DEBUG];
	end

	// State registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_reg                      <= PIO_RST_LATCH;
			pin_analog_digital_select_reg  <= PIO_RST_MDIN;
			pin_output_mode_select_reg     <= PIO_RST_MDOUT;
			pin_drive_strength_select_reg  <= PIO_RST_DRV;
			crossbar_skip_bit_reg          <= PIO_RST_SKIP;
			crossbar_enable_bit_reg        <= PIO_RST_XBAR;
			weak_pullup_global_disable_reg <= PIO_RST_PUD;
			wr_pend_reg                    <= 1'b0;
			wr_addr_reg                    <= 12'h000;
			hrdata                         <= 32'h0000_0000;
			hreadyout                      <= 1'b1;
			hresp                          <= PIO_HRESP_OKAY;
			xbar_avail                     <= PIO_XBAR_W'(PIO_XBAR_MASK);
			ext_osc_input_pin_ready        <= 1'b0;
			ext_osc_output_pin_ready       <= 1'b0;
			analog_ground_ref_pin_ready    <= 1'b0;
			debug_wire_data                <= 1'b0;
		end else begin
			latch_reg                      <= latch_next;
			pin_analog_digital_select_reg  <= pin_analog_digital_select_next;
			pin_output_mode_select_reg     <= pin_output_mode_select_next;
			pin_drive_strength_select_reg  <= pin_drive_strength_select_next;
			crossbar_skip_bit_reg          <= crossbar_skip_bit_next;
			crossbar_enable_bit_reg        <= crossbar_enable_bit_next;
			weak_pullup_global_disable_reg <= weak_pullup_global_disable_next;
			wr_pend_reg                    <= wr_pend_next;
			wr_addr_reg                    <= wr_addr_next;
			hrdata                         <= hrdata_next;
			hreadyout                      <= 1'b1;
			hresp                          <= PIO_HRESP_OKAY;
			xbar_avail                     <= xbar_avail_next;
			ext_osc_input_pin_ready        <= osc_in_next;
			ext_osc_output_pin_ready       <= osc_out_next;
			analog_ground_ref_pin_ready    <= analog_ground_ref_pin_next;
			debug_wire_data                <= dbg_next;
		end
	end

	// One cell per flat pin index; unpopulated cells are tied off.
	for (genvar g = 0; g < PIO_PIN_W; g++) begin : g_cell
		pio_cell #(
			.PRESENT (PIO_POP_MASK[g])
		) u_cell (
			.hclk       (hclk),
			.hresetn    (hresetn),
			.digital    (pin_analog_digital_select_reg[g]),
			.push_pull  (pin_pp_c[g]),
			.out_val    (pin_val_c[g]),
			.out_ok     (pin_ok_c[g]),
			.pud        (weak_pullup_global_disable_reg),
			.drv_high   (pin_drive_strength_select_reg[g]),
			.pad_oe     (pad_oe[g]),
			.pad_out    (pad_out[g]),
			.pullup_en  (pad_pullup_en[g]),
			.input_en   (pad_input_en[g]),
			.drive_high (pad_drive_high[g])
		);
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_read_input0;
		rd_take_c && rd_base_c == PIO_OFF_INPUT;
	endsequence

	sequence s_read_input1;
		rd_take_c && rd_base_c == PIO_OFF_INPUT && rd_sel_c != 8'h00;
	endsequence

	sequence s_xbar_off;
		!crossbar_enable_bit_reg && !debug_wire_active;
	endsequence

	a_pin_population: assert property (((pad_oe | pad_out | pad_pullup_en
		| pad_input_en | pad_drive_high) & ~PIO_POP_MASK) ==
		64'h0000_0000_0000_0000)
		else $error("Unpopulated pad cell is active.");
	a_reset_state: assert property ($rose(hresetn) |-> pad_oe == 64'h0
		&& pad_pullup_en == PIO_POP_MASK && pad_input_en == PIO_POP_MASK)
		else $error("Cells not high impedance with pull-ups after reset.");
	a_analog_reads_zero: assert property (s_read_input0 |=>
		(hrdata & {24'hFF_FFFF, ~$past(rd_sel_c)}) == 32'h0000_0000)
		else $error("Analog pin read back nonzero.");
	a_pad_readback: assert property (s_read_input1 |=>
		(hrdata[7:0] & $past(rd_sel_c)) ==
		($past(rd_pad_c) & $past(rd_sel_c)))
		else $error("Digital pin did not read the pad level.");
	a_drive_reset_low: assert property ($rose(hresetn) |->
		pad_drive_high == 64'h0)
		else $error("Drive strength not low after reset.");
	a_xbar_window: assert property (xbar_avail_next == PIO_XBAR_W'(
		~crossbar_skip_bit_next & PIO_XBAR_MASK) ##1
		xbar_avail == $past(xbar_avail_next))
		else $error("Crossbar availability outside P0.0 to P2.6.");
	a_skip_blocks_xbar: assert property ((xbar_avail &
		crossbar_skip_bit_reg[PIO_XBAR_W-1:0]) == 23'h00_0000)
		else $error("Skipped pin offered to the crossbar.");
	a_osc_fixed_pins: assert property (ext_osc_input_pin_ready |->
		crossbar_skip_bit_reg[PIO_PIN_OSC_IN]
		&& !pin_analog_digital_select_reg[PIO_PIN_OSC_IN])
		else $error("Oscillator input ready on an unprepared pin.");
	a_analog_ground_ref_pin_fixed_pin: assert property (analog_ground_ref_pin_ready |->
		crossbar_skip_bit_reg[PIO_PIN_ANALOG_GROUND_REF_PIN] && latch_reg[PIO_PIN_ANALOG_GROUND_REF_PIN])
		else $error("Ground reference ready on an unprepared pin.");
	a_debug_digital: assert property (
		pin_analog_digital_select_reg[PIO_PIN_DEBUG])
		else $error("Debug shared pin left analog.");
	a_drivers_gated: assert property (s_xbar_off ##1 s_xbar_off |->
		pad_oe == 64'h0)
		else $error("Pad driven while the crossbar is disabled.");
	a_latch_reset_high: assert property ($rose(hresetn) |->
		latch_reg == PIO_POP_MASK)
		else $error("Output latches did not reset to 1.");
	a_okay_zero_wait: assert property (hreadyout && hresp == PIO_HRESP_OKAY)
		else $error("Slave stalled or answered with an error.");

endmodule : pio_port_cfg
`default_nettype wire

// File: pio_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// Pads and board: each pad takes the cell's drive, else an outside driver,
// else the weak pull-up, else it floats.
module pio_pad_model
	import pio_pkg::*;
(
	input  wire logic                          hclk,
	input  wire logic [pio_pkg::PIO_PIN_W-1:0] pad_out,
	input  wire logic [pio_pkg::PIO_PIN_W-1:0] pad_oe,
	input  wire logic [pio_pkg::PIO_PIN_W-1:0] pad_pullup_en,
	input  wire logic [pio_pkg::PIO_PIN_W-1:0] ext_en,
	input  wire logic [pio_pkg::PIO_PIN_W-1:0] ext_val,
	output logic      [pio_pkg::PIO_PIN_W-1:0] pad_in
);
	logic [PIO_PIN_W-1:0] float_reg = 64'h5555_5555_5555_5555;

	// A floating pad flips every cycle so no stale level can pass for good.
	always @(posedge hclk) begin
		float_reg <= ~float_reg;
	end

	// Wire level seen by the receiver.
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
		| (~pad_oe & ~ext_en & (pad_pullup_en | float_reg));
endmodule : pio_pad_model
`default_nettype wire

// File: port_io_cell_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_io_cell_config_tb;
	import pio_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [63:0] pin;
	logic [63:0] pout;
	logic [63:0] poe;
	logic [63:0] pu;
	logic [63:0] ien;
	logic [63:0] dhi;
	logic [63:0] een;
	logic [63:0] evl;
	logic [22:0] xa;
	logic [22:0] xd;
	logic [22:0] avail;
	logic        dba;
	logic        dbe;
	logic        dbv;
	logic        dbd;
	wire  [2:0]  rdy;
	int          bad_count;
	int          checked;
	// Ordinary cases on port 3: select, mode, latch, drive, global, ext.
	logic [55:0] rows [7] = '{56'hFF_00FF_0000_0000, 56'hFF_000F_0001_0000,
		56'hFF_FFA5_3C01_0000, 56'hFF_FFA5_3C00_0F0A, 56'h0F_00FF_C302_FF3C,
		56'hFF_0000_0003_0000, 56'hFF_00FF_0001_FF55};

	pio_port_cfg DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pad_in(pin), .pad_out(pout),
		.pad_oe(poe), .pad_pullup_en(pu), .pad_input_en(ien),
		.pad_drive_high(dhi), .xbar_assign(xa), .xbar_data(xd),
		.xbar_avail(avail), .debug_wire_active(dba),
		.debug_wire_drive_en(dbe), .debug_wire_drive_val(dbv),
		.debug_wire_data(dbd), .ext_osc_input_pin_ready(rdy[2]),
		.ext_osc_output_pin_ready(rdy[1]),
		.analog_ground_ref_pin_ready(rdy[0]));

	pio_pad_model pads (.hclk(hclk), .pad_out(pout), .pad_oe(poe),
		.pad_pullup_en(pu), .ext_en(een), .ext_val(evl), .pad_in(pin));

	// Free-running bench clock.
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One single AHB-Lite transfer; read data lands in rd.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		hwrite <= w;
		htrans <= PIO_HTRANS_NSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(hresp, PIO_HRESP_OKAY);
	endtask : xfer

	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(rd, e);
	endtask : rdc

	task automatic settle;
		repeat (3) @(posedge hclk);
	endtask : settle

	task automatic run_row(input logic [55:0] r);
		logic [7:0] s, m, l, v, g, e, x, oe, up, lv;
		{s, m, l, v, g, e, x} = r;
		xfer(1'b1, PIO_OFF_MDIN + 12'h00C, s);
		xfer(1'b1, PIO_OFF_MDOUT + 12'h00C, m);
		xfer(1'b1, PIO_OFF_LATCH + 12'h00C, l);
		xfer(1'b1, PIO_OFF_DRV + 12'h00C, v);
		xfer(1'b1, PIO_OFF_GCTRL, g);
		een[31:24] <= e;
		evl[31:24] <= x;
		settle();
		oe = {8{g[0]}} & s & (m | ~l);
		up = s & ~oe & ~{8{g[1]}};
		lv = (oe & l) | (~oe & e & x) | (~oe & ~e & up);
		chk(poe[31:24], oe);
		chk(pout[31:24], oe & l);
		chk(pu[31:24], up);
		chk(ien[31:24], s);
		chk(dhi[31:24], v);
		rdc(PIO_OFF_INPUT + 12'h00C, s & lv);
		$display("row done at %0t", $time);
	endtask : run_row

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		tally_and_finish();
	end

	// Main sequence.
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{een, evl, xa, xd, dba, dbe, dbv} = '0;
		bad_count = 0;
		checked = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		chk(poe, 64'h0);
		chk(pu, PIO_POP_MASK);
		chk(ien, PIO_POP_MASK);
		chk(dhi, 64'h0);
		rdc(PIO_OFF_LATCH + 12'h01C, 8'h01);
		rdc(PIO_OFF_LATCH + 12'h018, 8'h0F);
		rdc(PIO_OFF_MDIN, 8'hFF);
		rdc(PIO_OFF_MDOUT, 8'h00);
		rdc(PIO_OFF_DRV, 8'h00);
		rdc(PIO_OFF_GCTRL, 8'h00);
		$display("reset test done");
		foreach (rows[i]) run_row(rows[i]);
		xfer(1'b1, 12'h100, 8'hFF);
		rdc(12'h100, 8'h00);
		xfer(1'b1, PIO_OFF_MDIN, 8'hF1);
		xfer(1'b1, PIO_OFF_MDOUT, 8'h10);
		xfer(1'b1, PIO_OFF_LATCH, 8'hFF);
		xfer(1'b1, PIO_OFF_SKIP, 8'h0E);
		xa[4] <= 1'b1;
		xa[2] <= 1'b1;
		xd[4] <= 1'b0;
		settle();
		chk(poe[4:1], 4'h8);
		chk(pout[4], 1'b0);
		chk(avail, 23'h7F_FFF1);
		chk(rdy, 3'h7);
		xfer(1'b1, PIO_OFF_SKIP, 8'h0A);
		settle();
		chk(rdy, 3'h3);
		$display("fixed pin test done");
		xfer(1'b1, PIO_OFF_GCTRL, 8'h00);
		xfer(1'b1, PIO_OFF_MDIN + 12'h01C, 8'h00);
		rdc(PIO_OFF_MDIN + 12'h01C, 8'h01);
		dba <= 1'b1;
		dbe <= 1'b1;
		settle();
		chk({poe[56], pout[56], dbd}, 3'h4);
		dbe <= 1'b0;
		settle();
		chk({poe[56], dbd}, 2'h1);
		$display("debug pin test done");
		// Mid-run reset puts every populated cell back to a pulled-up input.
		dba <= 1'b0;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(poe, 64'h0);
		chk(pu, PIO_POP_MASK);
		chk(avail, 23'h7F_FFFF);
		hresetn <= 1'b1;
		rdc(PIO_OFF_MDIN, 8'hFF);
		rdc(PIO_OFF_SKIP, 8'h00);
		rdc(PIO_OFF_LATCH + 12'h00C, 8'hFF);
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule : port_io_cell_config_tb
`default_nettype wire
